// [common/scc_consts.svh]
// Constants of the synthesizer configuration logic
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

// ----------------------------------------
// Pin vector layout
// ----------------------------------------
`define SCC_PIN_W          20
`define SCC_PIN_SER_STROBE 19
`define SCC_PIN_SER_DATA   18
`define SCC_PIN_SER_CLK    17
`define SCC_PIN_EXT_REF    16
`define SCC_PIN_PAR_LOAD_N 15
`define SCC_PIN_LOOP_HI    14
`define SCC_PIN_LOOP_LO    6
`define SCC_PIN_ODIV_HI    5
`define SCC_PIN_ODIV_LO    4
`define SCC_PIN_OUT_GATE   3
`define SCC_PIN_REF_SEL    2
`define SCC_PIN_CRYSTAL    1
`define SCC_PIN_VCO        0
// Pins with a pull-up; all others fall low when open
`define SCC_PIN_PULL_HIGH  20'h0fffc

// ----------------------------------------
// Field widths and reset values
// ----------------------------------------
`define SCC_LOOP_W         9
`define SCC_ODIV_W         2
`define SCC_TSEL_W         3
`define SCC_SHIFT_W        14
`define SCC_LOOP_RESET     9'h000
`define SCC_ODIV_RESET     2'h0
`define SCC_TSEL_RESET     3'h0
`define SCC_RATIO_RESET    4'h2

// ----------------------------------------
// Output divider codes
// ----------------------------------------
`define SCC_ODIV_BY2       2'h0
`define SCC_ODIV_BY4       2'h1
`define SCC_ODIV_BY8       2'h2
`define SCC_ODIV_BY1       2'h3

`endif

// [common/scc_pkg.sv]
// Types of the synthesizer configuration logic
package scc_pkg;

   typedef struct packed {
      logic       ser_strobe;
      logic       ser_data;
      logic       ser_clk;
      logic       external_reference_in;
      logic       par_load_n;
      logic [8:0] loop_div;
      logic [1:0] out_div;
      logic       out_gate;
      logic       reference_source_select;
      logic       crystal;
      logic       vco;
   } scc_pins_t;

   typedef struct packed {
      logic [2:0] test_sel;
      logic [1:0] out_div;
      logic [8:0] loop_div;
   } scc_cfg_t;

   typedef enum logic [2:0] {
      SCC_TEST_SYNTH_OUT,
      SCC_TEST_REFERENCE,
      SCC_TEST_VCO,
      SCC_TEST_FEEDBACK,
      SCC_TEST_SHIFT_OUT,
      SCC_TEST_LOW,
      SCC_TEST_HIGH,
      SCC_TEST_VCO_DIV8
   } scc_test_sel_t;

endpackage

// [logic/scc_config.sv]
// Configuration, reference select, output divider and gate of the synthesizer
`timescale 1ns/1ps
`include "scc_consts.svh"

// Notes on behaviour
// - Divider code 00 divides VCO by 2, 01 by 4, 10 by 8, 11 by 1.
// - Latches follow the shift register while serial strobe high, hold at its fall.
// - Shift register takes serial data on each rising serial clock edge.
// - Latches follow parallel pins while parallel strobe low, hold at its rise.
// - Nine-bit loop divider taken from parallel pins at strobe rise, bit 8 MSB.
// - Two-bit output divider code taken at the same parallel strobe rise.
// - Output gate high enables; changes only while output is low, no runt pulse.
// - Reference select high routes crystal, low routes the external reference.
// - Test output function picked by three-bit field loaded only serially.
// - Open serial strobe, data, clock and external reference read low.
// - Open parallel strobe, dividers, gate and reference select read high.
module scc_config
   import scc_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire logic      rst,
   input  wire scc_pins_t pin_level,
   input  wire scc_pins_t pin_driven,
   output scc_cfg_t       cfg,
   output logic [3:0]     out_divide_ratio,
   output logic           synth_clock_out,
   output logic           outputs_enabled,
   output logic           pll_reference,
   output logic           test_out
);

   // ----------------------------------------
   // Pin resolution and synchronisers
   // ----------------------------------------
   // Pull levels as a vector, so each synchroniser bit resets to its own level
   localparam logic [`SCC_PIN_W-1:0] pull_level = `SCC_PIN_PULL_HIGH;

   logic [`SCC_PIN_W-1:0] pin_raw;
   logic [`SCC_PIN_W-1:0] pin_meta;
   logic [`SCC_PIN_W-1:0] pin_sync;
   scc_pins_t             pin_s;

   // Undriven pins fall to their pull level
   assign pin_raw = (pin_level & pin_driven) |
                    (`SCC_PIN_PULL_HIGH & ~pin_driven);

   genvar gi;
   generate
      for (gi = 0; gi < `SCC_PIN_W; gi = gi + 1)
      begin : g_sync
         always_ff @(posedge ref_clk)
         begin
            if (rst)
            begin
               pin_meta[gi] <= pull_level[gi];
               pin_sync[gi] <= pull_level[gi];
            end
            else
            begin
               pin_meta[gi] <= pin_raw[gi];
               pin_sync[gi] <= pin_meta[gi];
            end
         end
      end
   endgenerate

   assign pin_s = pin_sync;

   // ----------------------------------------
   // Edge detection on synchronised pins
   // ----------------------------------------
   logic ser_clk_d;
   logic vco_d;
   logic ser_clk_rise;
   logic vco_rise;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ser_clk_d <= 1'b0;
         vco_d     <= 1'b0;
      end
      else
      begin
         ser_clk_d <= pin_s.ser_clk;
         vco_d     <= pin_s.vco;
      end
   end

   assign ser_clk_rise = pin_s.ser_clk & ~ser_clk_d;
   assign vco_rise     = pin_s.vco & ~vco_d;

   // ----------------------------------------
   // Serial shift register
   // ----------------------------------------
   // Shifted MSB first; after a full frame the layout is {test, out_div, loop}
   logic [`SCC_SHIFT_W-1:0] shift_reg;
   logic [`SCC_SHIFT_W-1:0] next_shift_reg;

   assign next_shift_reg = {shift_reg[`SCC_SHIFT_W-2:0], pin_s.ser_data};

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         shift_reg <= '0;
      else if (ser_clk_rise)
         shift_reg <= next_shift_reg;
   end

   // ----------------------------------------
   // Configuration latches
   // ----------------------------------------
   // Parallel load wins when both strobes are active; it is the power-up path
   // and the serial path is expected to be quiet then.
   logic     par_open;
   logic     ser_open;
   scc_cfg_t shift_cfg;
   scc_cfg_t next_cfg;

   assign par_open  = ~pin_s.par_load_n;
   assign ser_open  = pin_s.ser_strobe;
   assign shift_cfg = shift_reg;

   always_comb
   begin
      next_cfg = cfg;
      if (par_open)
      begin
         next_cfg.loop_div = pin_s.loop_div;
         next_cfg.out_div  = pin_s.out_div;
      end
      else if (ser_open)
         next_cfg = shift_cfg;
   end

   // Transparent while open; the last open cycle value is what is held
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         cfg <= '{test_sel: `SCC_TSEL_RESET,
                  out_div:  `SCC_ODIV_RESET,
                  loop_div: `SCC_LOOP_RESET};
      else
         cfg <= next_cfg;
   end

   // ----------------------------------------
   // Output divider
   // ----------------------------------------
   // Bit k of the rise counter toggles every 2**k VCO rises: a divide by 2**(k+1)
   logic [2:0] vco_cnt;
   logic       div_level;
   logic [1:0] div_code;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         vco_cnt <= 3'h0;
      else if (vco_rise)
         vco_cnt <= vco_cnt + 3'h1;
   end

   // A new divider code is taken only while the divided level is low, so a
   // code change never cuts a high phase short. Limitation: with the VCO
   // stopped high in divide by 1 the old code stays in force.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         div_code <= `SCC_ODIV_RESET;
      else if (!div_level)
         div_code <= cfg.out_div;
   end

   always_comb
   begin
      unique case (div_code)
         `SCC_ODIV_BY2: div_level = vco_cnt[0];
         `SCC_ODIV_BY4: div_level = vco_cnt[1];
         `SCC_ODIV_BY8: div_level = vco_cnt[2];
         `SCC_ODIV_BY1: div_level = pin_s.vco;
      endcase
   end

   // Decoded from the next latch value, so the registered ratio never lags cfg
   logic [3:0] next_out_divide_ratio;

   always_comb
   begin
      unique case (next_cfg.out_div)
         `SCC_ODIV_BY2: next_out_divide_ratio = 4'h2;
         `SCC_ODIV_BY4: next_out_divide_ratio = 4'h4;
         `SCC_ODIV_BY8: next_out_divide_ratio = 4'h8;
         `SCC_ODIV_BY1: next_out_divide_ratio = 4'h1;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         out_divide_ratio <= `SCC_RATIO_RESET;
      else
         out_divide_ratio <= next_out_divide_ratio;
   end

   // ----------------------------------------
   // Synchronous output gate
   // ----------------------------------------
   // The gate only moves while the divided clock is low, so the output never
   // starts or stops part way through a high phase; divider code changes are
   // held back the same way in div_code.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         outputs_enabled <= 1'b0;
         synth_clock_out <= 1'b0;
      end
      else
      begin
         if (!div_level)
            outputs_enabled <= pin_s.out_gate;
         synth_clock_out <= div_level & outputs_enabled;
      end
   end

   // ----------------------------------------
   // Reference select
   // ----------------------------------------
   logic ref_mux;

   assign ref_mux = pin_s.reference_source_select ? pin_s.crystal
                                                  : pin_s.external_reference_in;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         pll_reference <= 1'b0;
      else
         pll_reference <= ref_mux;
   end

   // ----------------------------------------
   // Loop feedback divider, seen on the test output
   // ----------------------------------------
   // Toggles after loop_div VCO rises; a value of zero is treated as one
   logic [`SCC_LOOP_W-1:0] fb_cnt;
   logic                   fb_wrap;
   logic                   fb_level;

   assign fb_wrap = (fb_cnt + 9'h001 >= cfg.loop_div);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         fb_cnt   <= '0;
         fb_level <= 1'b0;
      end
      else if (vco_rise)
      begin
         if (fb_wrap)
         begin
            fb_cnt   <= '0;
            fb_level <= ~fb_level;
         end
         else
            fb_cnt <= fb_cnt + 9'h001;
      end
   end

   // ----------------------------------------
   // Test output select
   // ----------------------------------------
   scc_test_sel_t test_sel;
   logic          test_mux;

   assign test_sel = scc_test_sel_t'(cfg.test_sel);

   always_comb
   begin
      unique case (test_sel)
         SCC_TEST_SYNTH_OUT: test_mux = synth_clock_out;
         SCC_TEST_REFERENCE: test_mux = pll_reference;
         SCC_TEST_VCO:       test_mux = pin_s.vco;
         SCC_TEST_FEEDBACK:  test_mux = fb_level;
         SCC_TEST_SHIFT_OUT: test_mux = shift_reg[`SCC_SHIFT_W-1];
         SCC_TEST_LOW:       test_mux = 1'b0;
         SCC_TEST_HIGH:      test_mux = 1'b1;
         SCC_TEST_VCO_DIV8:  test_mux = vco_cnt[2];
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         test_out <= 1'b0;
      else
         test_out <= test_mux;
   end

endmodule // scc_config

// [verification/scc_config_assertions.sv]
// Assertion checker for the synthesizer configuration logic
`timescale 1ns/1ps
`include "scc_consts.svh"
module scc_config_assertions
   import scc_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire scc_pins_t  pin_level,
   input wire scc_pins_t  pin_driven,
   input wire scc_cfg_t   cfg,
   input wire logic [3:0] out_divide_ratio,
   input wire logic       synth_clock_out,
   input wire logic       outputs_enabled,
   input wire logic       pll_reference,
   input wire logic       test_out
);
   // Pins as the logic sees them, open ones at their pull level
   scc_pins_t e;
   assign e = (pin_level & pin_driven) | (~pin_driven & `SCC_PIN_PULL_HIGH);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_RATIO:
   assert property (out_divide_ratio == (cfg.out_div == 2'h0 ? 4'h2 :
      cfg.out_div == 2'h1 ? 4'h4 : cfg.out_div == 2'h2 ? 4'h8 : 4'h1))
      else $error("divide ratio decode wrong");
   AST_REF:
   assert property (($stable(e.reference_source_select) && $stable(e.crystal)
      && $stable(e.external_reference_in))[*5] |-> pll_reference ==
      (e.reference_source_select ? e.crystal : e.external_reference_in))
      else $error("reference source wrong");
   AST_PAR:
   assert property ((!e.par_load_n && $stable(e.loop_div) && $stable(e.out_div))[*5]
      |-> cfg.loop_div == e.loop_div && cfg.out_div == e.out_div)
      else $error("parallel load wrong");
   AST_LOAD:
   assert property (!$stable(cfg) |-> $past(e.ser_strobe, 3) || $past(e.ser_strobe, 4)
      || !$past(e.par_load_n, 3) || !$past(e.par_load_n, 4))
      else $error("config changed without a strobe");
   AST_TSEL:
   assert property (!$stable(cfg.test_sel) |-> $past(e.ser_strobe, 3)
      || $past(e.ser_strobe, 4))
      else $error("test select loaded without serial strobe");
   AST_GATE:
   assert property (synth_clock_out |-> $past(outputs_enabled))
      else $error("output high while disabled");
   AST_NORUNT:
   assert property (!$stable(outputs_enabled) |-> !synth_clock_out)
      else $error("gate changed during high phase");
   AST_TLOW:
   assert property (cfg.test_sel == SCC_TEST_LOW [*3] |-> !test_out)
      else $error("test output not low");
   AST_THIGH:
   assert property (cfg.test_sel == SCC_TEST_HIGH [*3] |-> test_out)
      else $error("test output not high");
   cover property (!e.par_load_n ##1 e.par_load_n);
   cover property ($fell(e.ser_strobe));
   cover property ($rose(outputs_enabled));
endmodule // scc_config_assertions

bind scc_config scc_config_assertions u_chk (.ref_clk, .rst, .pin_level, .pin_driven,
   .cfg, .out_divide_ratio, .synth_clock_out, .outputs_enabled, .pll_reference, .test_out);

// [verification/scc_host_model.sv]
// Host controller model driving the serial and parallel configuration pins
`timescale 1ns/1ps
module scc_host_model
   import scc_pkg::*;
(
   input  wire logic ref_clk,
   output scc_pins_t hl,
   output scc_pins_t hd
);
   initial
   begin
      hl = '0;
      hd = 20'ha0000;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Serial frame, first bit on top; g cycles per half link period
   task automatic ser_frame(input logic [13:0] w, input int g);
      hd.ser_data = 1'b1;
      for (int i = 13; i >= 0; i--)
      begin
         hl.ser_data = w[i];
         wt(g);
         hl.ser_clk = 1'b1;
         wt(g);
         hl.ser_clk = 1'b0;
      end
      wt(g);
      hl.ser_strobe = 1'b1;
      wt(g);
      hl.ser_strobe = 1'b0;
      wt(g);
      // Released data line falls to its pull-down
      hd.ser_data = 1'b0;
      hl.ser_data = ~hl.ser_data;
   endtask
   task automatic par_load(input logic [8:0] m, input logic [1:0] n, input int g);
      hd.loop_div = '1;
      hd.out_div = '1;
      hd.par_load_n = 1'b1;
      hl.loop_div = m;
      hl.out_div = n;
      hl.par_load_n = 1'b0;
      wt(g);
      hl.par_load_n = 1'b1;
      wt(g);
      hd.loop_div = '0;
      hd.out_div = '0;
      hd.par_load_n = 1'b0;
   endtask
endmodule // scc_host_model

// [verification/testbench.sv]
// Self-checking testbench for the synthesizer configuration logic
`timescale 1ns/1ps
module testbench
   import scc_pkg::*;
;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   scc_pins_t  hl, hd, bl, bd;
   scc_cfg_t   cfg;
   logic [3:0] out_divide_ratio;
   logic       synth_clock_out, outputs_enabled, pll_reference, test_out;
   logic [2:0] vc = 3'h0;
   int         fail_count = 0;
   int         n_tests = 0;
   int         cyc = 0;
   int         r;
   logic       watch_test = 1'b0;
   // Loop divider, divider code, output rises in 124 cycles, divide ratio
   logic [18:0] rows [4] = '{{9'h1ff, 2'h0, 4'h7, 4'h2}, {9'h100, 2'h1, 4'h3, 4'h4},
      {9'h001, 2'h2, 4'h1, 4'h8}, {9'h0aa, 2'h3, 4'hf, 4'h1}};
   wire scc_pins_t pl = hl | bl | {19'h0, vc[2]};
   wire scc_pins_t pd = hd | bd | 20'h00001;
   wire logic watched = watch_test ? test_out : synth_clock_out;
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) vc <= vc + 3'h1;
   scc_config dut (.ref_clk, .rst, .pin_level(pl), .pin_driven(pd), .cfg,
      .out_divide_ratio, .synth_clock_out, .outputs_enabled, .pll_reference, .test_out);
   scc_host_model host (.ref_clk, .hl, .hd);
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Settle first, so a divider switch leaves no odd period in the count
   task automatic rises(output int n);
      logic p;
      n = 0;
      p = 1'b1;
      wt(70);
      for (int k = 0; k < 300 && !(p === 1'b0 && watched === 1'b1); k++)
      begin
         p = watched;
         wt(1);
      end
      repeat (124)
      begin
         p = watched;
         wt(1);
         if (p === 1'b0 && watched === 1'b1)
            n++;
      end
   endtask
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 10000)
      begin
         fail_count++;
         end_of_test;
      end
   end
   initial
   begin
      bl = '0;
      bd = 20'h10002;
      wt(3);
      chk(cfg, 14'h0000);
      chk({10'h0, out_divide_ratio}, 14'h0002);
      rst = 1'b0;
      wt(4);
      foreach (rows[i])
      begin
         host.par_load(rows[i][18:10], rows[i][9:8], 3 + i);
         chk({3'h0, cfg.out_div, cfg.loop_div}, {3'h0, rows[i][9:8], rows[i][18:10]});
         chk({10'h0, out_divide_ratio}, {10'h0, rows[i][3:0]});
         rises(r);
         chk(14'(r), {10'h0, rows[i][7:4]});
      end
      host.ser_frame({SCC_TEST_LOW, 2'h1, 9'h123}, 4);
      chk(cfg, {SCC_TEST_LOW, 2'h1, 9'h123});
      chk({13'h0, test_out}, 14'h0000);
      host.ser_frame({SCC_TEST_HIGH, 2'h3, 9'h0f0}, 4);
      host.par_load(9'h055, 2'h2, 4);
      chk(cfg, {SCC_TEST_HIGH, 2'h2, 9'h055});
      chk({13'h0, test_out}, 14'h0001);
      bd.out_gate = 1'b1;
      wt(80);
      chk({12'h0, outputs_enabled, synth_clock_out}, 14'h0000);
      bd.out_gate = 1'b0;
      wt(80);
      chk({13'h0, outputs_enabled}, 14'h0001);
      bl.crystal = 1'b1;
      wt(5);
      chk({13'h0, pll_reference}, 14'h0001);
      bd.reference_source_select = 1'b1;
      wt(5);
      chk({13'h0, pll_reference}, 14'h0000);
      bl.external_reference_in = 1'b1;
      wt(5);
      chk({13'h0, pll_reference}, 14'h0001);
      bd.external_reference_in = 1'b0;
      wt(5);
      chk({13'h0, pll_reference}, 14'h0000);
      host.ser_frame({SCC_TEST_REFERENCE, 2'h1, 9'h002}, 4);
      bd.external_reference_in = 1'b1;
      wt(5);
      chk({12'h0, pll_reference, test_out}, 14'h0003);
      watch_test = 1'b1;
      host.ser_frame({SCC_TEST_SYNTH_OUT, 2'h1, 9'h002}, 4);
      rises(r);
      chk(14'(r), 14'h0003);
      host.ser_frame({SCC_TEST_VCO, 2'h1, 9'h002}, 4);
      rises(r);
      chk(14'(r), 14'h000f);
      host.ser_frame({SCC_TEST_FEEDBACK, 2'h1, 9'h001}, 4);
      rises(r);
      chk(14'(r), 14'h0007);
      host.ser_frame({SCC_TEST_VCO_DIV8, 2'h1, 9'h002}, 4);
      rises(r);
      chk(14'(r), 14'h0001);
      host.ser_frame({SCC_TEST_SHIFT_OUT, 2'h1, 9'h002}, 4);
      chk({13'h0, test_out}, 14'h0001);
      rst = 1'b1;
      wt(2);
      chk(cfg, 14'h0000);
      chk({10'h0, out_divide_ratio}, 14'h0002);
      rst = 1'b0;
      wt(3);
      end_of_test;
   end
endmodule // testbench
